/* File: verilog/reset_boot_sync_controller.sv */
// Purpose: reset, self-test, boot source, eeprom loader and sync retiming
// Assumes: APB master on clk; pins asynchronous to clk
// Notes: TEST_CYCLES may be shortened for simulation
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
module reset_boot_sync_controller #(
  parameter int unsigned TEST_CYCLES = boot_ctrl_pkg::TEST_CYCLES,
  parameter logic [7:0]  START_CMD   = boot_ctrl_pkg::CMD_START_DEF
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   boot_pin,
  input  wire logic                   sync_pin,
  input  wire logic                   miso_pin,
  input  wire logic [4:0]             check_fail,
  input  wire logic [7:0]             paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  output boot_ctrl_pkg::serial_pins_s serial_pins,
  output logic                        modulator_align_pulse,
  output logic                        filter_restart,
  output logic                        stream_pointer_reset,
  output logic                        modulator_clock,
  output logic                        filter_running
);
  boot_ctrl_pkg::boot_state_e state_q;
  logic [1:0]  boot_s_q;
  logic [1:0]  sync_s_q;
  logic [1:0]  miso_s_q;
  logic        sync_d1_q;
  logic        sync_rise;
  logic [boot_ctrl_pkg::TEST_CNT_W-1:0] test_cnt_q;
  logic        test_done;
  logic        boot_q;
  logic        boot_valid_q;
  logic [23:0] cfg_q;
  logic [23:0] tbs_q;
  logic [23:0] result_q;
  logic [5:0]  div_q;
  logic        tick_q;
  logic        mod_clk_q;
  logic        ee_start_q;
  logic        ee_busy_q;
  logic        ee_done;
  logic [23:0] ee_rdata;
  logic [15:0] ee_addr_q;
  logic [7:0]  cmd_q;
  logic [10:0] words_left_q;
  logic [10:0] left_d;
  logic [1:0]  word_idx_q;
  logic [7:0]  count_q;
  logic [5:0]  reg_sel_q;
  logic        ee_wr;
  logic        running_q;
  logic        align_q;
  logic        restart_q;
  logic        ptr_rst_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        apb_setup;
  logic        apb_wr;
  logic [5:0]  idx;
  logic        addr_ok;
  logic [23:0] rd_mux;

  assign prdata                = prdata_q;
  assign pready                = pready_q;
  assign pslverr               = pslverr_q;
  assign modulator_align_pulse = align_q;
  assign filter_restart        = restart_q;
  assign stream_pointer_reset  = ptr_rst_q;
  assign modulator_clock       = mod_clk_q;
  assign filter_running        = running_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_s_q  <= 2'h0;
      sync_s_q  <= 2'h0;
      miso_s_q  <= 2'h0;
      sync_d1_q <= 1'b0;
    end else begin
      boot_s_q  <= {boot_s_q[0], boot_pin};
      sync_s_q  <= {sync_s_q[0], sync_pin};
      miso_s_q  <= {miso_s_q[0], miso_pin};
      sync_d1_q <= sync_s_q[1];
    end
  end

  assign sync_rise = sync_s_q[1] & ~sync_d1_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      test_cnt_q <= '0;
    end else if (state_q == boot_ctrl_pkg::ST_TEST) begin
      test_cnt_q <= test_cnt_q + 1'b1;
    end
  end

  assign test_done = (state_q == boot_ctrl_pkg::ST_TEST) &&
                     (test_cnt_q == boot_ctrl_pkg::TEST_CNT_W'(TEST_CYCLES - 1));

  // boot source caught once after release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_q       <= 1'b0;
      boot_valid_q <= 1'b0;
    end else if (!boot_valid_q &&
                 test_cnt_q == boot_ctrl_pkg::TEST_CNT_W'(boot_ctrl_pkg::BOOT_LATCH_AT)) begin
      boot_q       <= boot_s_q[1];
      boot_valid_q <= 1'b1;
    end
  end

  // pass or fail nibble per test
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= boot_ctrl_pkg::RESULT_RESET;
    end else if (test_done) begin
      for (int i = 0; i < boot_ctrl_pkg::NUM_TESTS; i++) begin
        result_q[4*i +: 4] <= check_fail[i] ? boot_ctrl_pkg::CODE_FAIL : boot_ctrl_pkg::CODE_PASS;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q     <= 6'h0;
      tick_q    <= 1'b0;
      mod_clk_q <= 1'b0;
    end else if (div_q == 6'(boot_ctrl_pkg::SCK_HALF - 1)) begin
      div_q     <= 6'h0;
      tick_q    <= 1'b1;
      mod_clk_q <= ~mod_clk_q;
    end else begin
      div_q  <= div_q + 6'h1;
      tick_q <= 1'b0;
    end
  end

  // word count after this word, counts taken from data
  always_comb begin
    left_d = words_left_q - 11'h1;
    if (cmd_q == boot_ctrl_pkg::CMD_FIR && word_idx_q == 2'h1) begin
      left_d = {3'h0, count_q} + {3'h0, ee_rdata[7:0]};
    end
    if (cmd_q == boot_ctrl_pkg::CMD_TBS && word_idx_q == 2'h0) begin
      left_d = ee_rdata[10:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= boot_ctrl_pkg::ST_TEST;
    end else begin
      unique case (state_q)
        boot_ctrl_pkg::ST_TEST: begin
          if (test_done) begin
            state_q <= boot_q ? boot_ctrl_pkg::ST_CMD : boot_ctrl_pkg::ST_HOST;
          end
        end
        boot_ctrl_pkg::ST_CMD: begin
          if (ee_done) begin
            if (ee_rdata[7:0] == START_CMD) begin
              state_q <= boot_ctrl_pkg::ST_RUN;
            end else if (boot_ctrl_pkg::words_for_cmd(ee_rdata[7:0]) != 11'h0) begin
              state_q <= boot_ctrl_pkg::ST_DATA;
            end
          end
        end
        boot_ctrl_pkg::ST_DATA: begin
          if (ee_done && left_d == 11'h0) begin
            state_q <= boot_ctrl_pkg::ST_CMD;
          end
        end
        boot_ctrl_pkg::ST_RUN:  state_q <= boot_ctrl_pkg::ST_RUN;
        boot_ctrl_pkg::ST_HOST: state_q <= boot_ctrl_pkg::ST_HOST;
        default:                state_q <= boot_ctrl_pkg::ST_TEST;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q        <= 8'h00;
      words_left_q <= 11'h0;
      word_idx_q   <= 2'h0;
      count_q      <= 8'h00;
      reg_sel_q    <= 6'h0;
    end else if (ee_done && state_q == boot_ctrl_pkg::ST_CMD) begin
      cmd_q        <= ee_rdata[7:0];
      words_left_q <= boot_ctrl_pkg::words_for_cmd(ee_rdata[7:0]);
      word_idx_q   <= 2'h0;
    end else if (ee_done && state_q == boot_ctrl_pkg::ST_DATA) begin
      words_left_q <= left_d;
      if (word_idx_q != 2'h3) begin
        word_idx_q <= word_idx_q + 2'h1;
      end
      if (word_idx_q == 2'h0) begin
        count_q   <= ee_rdata[7:0];
        reg_sel_q <= ee_rdata[5:0];
      end
    end
  end

  assign ee_wr = ee_done && state_q == boot_ctrl_pkg::ST_DATA &&
                 cmd_q == boot_ctrl_pkg::CMD_WR_REG && word_idx_q == 2'h1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ee_start_q <= 1'b0;
      ee_busy_q  <= 1'b0;
      ee_addr_q  <= boot_ctrl_pkg::EE_START;
    end else begin
      ee_start_q <= (state_q == boot_ctrl_pkg::ST_CMD || state_q == boot_ctrl_pkg::ST_DATA) &&
                    !ee_busy_q && !ee_start_q && !ee_done;
      if (ee_start_q) begin
        ee_busy_q <= 1'b1;
      end else if (ee_done) begin
        ee_busy_q <= 1'b0;
        ee_addr_q <= ee_addr_q + ((state_q == boot_ctrl_pkg::ST_DATA) ? 16'h0003 : 16'h0001);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      running_q <= 1'b0;
    end else if (state_q == boot_ctrl_pkg::ST_RUN) begin
      running_q <= 1'b1;
    end
  end

  eeprom_reader u_reader (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (tick_q),
    .start (ee_start_q),
    .word  (state_q == boot_ctrl_pkg::ST_DATA),
    .addr  (ee_addr_q),
    .miso  (miso_s_q[1]),
    .pins  (serial_pins),
    .rdata (ee_rdata),
    .done  (ee_done)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      align_q   <= 1'b0;
      restart_q <= 1'b0;
      ptr_rst_q <= 1'b0;
    end else begin
      align_q   <= sync_rise & cfg_q[boot_ctrl_pkg::MODULATOR_SYNC_ENABLE_BIT];
      restart_q <= sync_rise & cfg_q[boot_ctrl_pkg::MODULATOR_SYNC_ENABLE_BIT];
      ptr_rst_q <= sync_rise & cfg_q[boot_ctrl_pkg::MODULATOR_SYNC_ENABLE_BIT] &
                   tbs_q[boot_ctrl_pkg::TBS_EN_BIT] & tbs_q[boot_ctrl_pkg::STREAM_POINTER_SYNC_ENABLE_BIT];
    end
  end

  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pready_q & pwrite & ~pslverr_q;
  assign idx       = paddr[7:2];
  assign addr_ok   = (paddr[1:0] == 2'h0) &&
                     (idx == boot_ctrl_pkg::IDX_CFG || idx == boot_ctrl_pkg::IDX_TBS ||
                      idx == boot_ctrl_pkg::IDX_RESULT || idx == boot_ctrl_pkg::IDX_STATUS);

  always_comb begin
    rd_mux = 24'h0;
    unique case (idx)
      boot_ctrl_pkg::IDX_CFG:    rd_mux = cfg_q;
      boot_ctrl_pkg::IDX_TBS:    rd_mux = tbs_q;
      boot_ctrl_pkg::IDX_RESULT: rd_mux = result_q;
      boot_ctrl_pkg::IDX_STATUS: rd_mux = {18'h0, running_q, boot_valid_q, boot_q, state_q};
      default:                   rd_mux = 24'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= apb_setup;
      pslverr_q <= apb_setup & (~addr_ok | (pwrite & (state_q == boot_ctrl_pkg::ST_TEST ||
                   idx == boot_ctrl_pkg::IDX_RESULT || idx == boot_ctrl_pkg::IDX_STATUS)));
      prdata_q  <= (apb_setup & ~pwrite & addr_ok) ? {8'h00, rd_mux} : 32'h0;
    end
  end

  // register writes from bus or eeprom
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= boot_ctrl_pkg::CFG_RESET;
      tbs_q <= boot_ctrl_pkg::TBS_RESET;
    end else if (ee_wr) begin
      if (reg_sel_q == boot_ctrl_pkg::IDX_CFG) cfg_q <= ee_rdata;
      if (reg_sel_q == boot_ctrl_pkg::IDX_TBS) tbs_q <= ee_rdata;
    end else if (apb_wr) begin
      if (idx == boot_ctrl_pkg::IDX_CFG) cfg_q <= pwdata[23:0];
      if (idx == boot_ctrl_pkg::IDX_TBS) tbs_q <= pwdata[23:0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  align_pulse_a: assert property (sync_rise && cfg_q[0] |=> align_q && restart_q)
    else $error("align pulse missing after sync edge");
  align_gate_a: assert property (!(sync_rise && cfg_q[0]) |=> !align_q)
    else $error("align pulse without enabled sync edge");
  stream_reset_a: assert property (ptr_rst_q |-> align_q && $past(tbs_q[1]) && $past(tbs_q[0]))
    else $error("stream pointer reset without stream sync");
  test_refuse_a: assert property (apb_setup && pwrite && state_q == boot_ctrl_pkg::ST_TEST |=> pslverr_q)
    else $error("write accepted during self-test");
  test_len_a: assert property ($past(state_q) == boot_ctrl_pkg::ST_TEST && state_q != boot_ctrl_pkg::ST_TEST
                               |-> $past(test_cnt_q) == boot_ctrl_pkg::TEST_CNT_W'(TEST_CYCLES - 1))
    else $error("self-test phase ended at wrong count");
  result_code_a: assert property (test_done |=> result_q[3:0] inside {4'hA, 4'hF} &&
                                  result_q[19:16] inside {4'hA, 4'hF} && result_q[23:20] == 4'h0)
    else $error("self-test result code malformed");
  host_quiet_a: assert property (state_q == boot_ctrl_pkg::ST_HOST |-> serial_pins.cs_oe_n &&
                                 serial_pins.sck_oe_n && serial_pins.mosi_oe_n)
    else $error("serial activity in host boot");
  boot_path_a: assert property (test_done |=> state_q == (boot_q ? boot_ctrl_pkg::ST_CMD : boot_ctrl_pkg::ST_HOST))
    else $error("boot path does not match latched pin");
  frame_hold_a: assert property (serial_pins.sck |-> !serial_pins.cs_n && !serial_pins.cs_oe_n)
    else $error("config clock high outside select");
  first_addr_a: assert property ($rose(ee_busy_q) && state_q == boot_ctrl_pkg::ST_CMD && cmd_q == 8'h00
                                 && words_left_q == 11'h0 && $past(state_q, 3) == boot_ctrl_pkg::ST_TEST
                                 |-> ee_addr_q == boot_ctrl_pkg::EE_START)
    else $error("first fetch not at start address");

  run_reached_c: cover property ($rose(running_q));
  host_wait_c:   cover property (state_q == boot_ctrl_pkg::ST_HOST);
  stream_sync_c: cover property (ptr_rst_q);
endmodule : reset_boot_sync_controller

/* File: verilog/boot_ctrl_pkg.sv */
// Behaviour
// - reset input active low, holds all logic
// - latch boot pin after release; 1 eeprom
// - self-tests run before any boot activity
// - each test writes A or F nibble
// - 60 ms test phase; no commands before
// - eeprom boot fetches config, then runs
// - host boot stays idle, no serial activity
// - derived clocks come from one master clock
// - sync rising edge makes retimed align pulse
// - align pulse only while sync enable set
// - align pulse restarts filter state machine
// - periodic sync lands on convolution start; code pulses on every enabled sync edge with no convolution alignment
// - stream pointer reset when stream sync set
// - chip select low frames each transaction
// - device makes config clock, about 1.024 MHz
// - data out changes on falling clock edge
// - data in sampled on rising clock edge
// - opcode, 16-bit address, byte or word read
// - only select, clock, two data pins active
// - port pins high impedance when idle
// - read opcode 0x03 then start address
// - fetching starts at eeprom address 0x10
// - command then data words until start command
//
// Purpose: constants and types of the reset, boot and sync controller
// Assumes: 100 MHz clk, APB register access
// Notes: register index times four is the byte address
package boot_ctrl_pkg;
  localparam int CLK_KHZ     = 100000;
  localparam int SCK_HZ      = 1024000;
  localparam int SCK_HALF    = CLK_KHZ * 1000 / (2 * SCK_HZ);
  localparam int TEST_MS     = 60;
  localparam int TEST_CYCLES = TEST_MS * CLK_KHZ;
  localparam int TEST_CNT_W  = 23;
  localparam int BOOT_LATCH_AT = 3;

  localparam logic [5:0] IDX_CFG    = 6'h00;
  localparam logic [5:0] IDX_TBS    = 6'h2A;
  localparam logic [5:0] IDX_RESULT = 6'h2F;
  localparam logic [5:0] IDX_STATUS = 6'h30;
  localparam logic [23:0] CFG_RESET    = 24'h000000;
  localparam logic [23:0] TBS_RESET    = 24'h000000;
  localparam logic [23:0] RESULT_RESET = 24'h000000;
  localparam int MODULATOR_SYNC_ENABLE_BIT   = 0;
  localparam int TBS_EN_BIT = 0;
  localparam int STREAM_POINTER_SYNC_ENABLE_BIT  = 1;
  localparam int NUM_TESTS  = 5;
  localparam logic [3:0] CODE_PASS = 4'hA;
  localparam logic [3:0] CODE_FAIL = 4'hF;

  localparam logic [7:0]  OP_READ  = 8'h03;
  localparam logic [15:0] EE_START = 16'h0010;
  localparam logic [5:0]  HDR_BITS = 6'h18;
  localparam logic [5:0]  LAST_BYTE = 6'h1F;
  localparam logic [5:0]  LAST_WORD = 6'h2F;
  localparam logic [7:0] CMD_WR_REG = 8'h01;
  localparam logic [7:0] CMD_FIR    = 8'h02;
  localparam logic [7:0] CMD_IIR    = 8'h03;
  localparam logic [7:0] CMD_ROM    = 8'h04;
  localparam logic [7:0] CMD_TBS    = 8'h05;
  localparam logic [7:0] CMD_START_DEF = 8'h06;

  typedef struct packed {
    logic cs_n;
    logic cs_oe_n;
    logic sck;
    logic sck_oe_n;
    logic mosi;
    logic mosi_oe_n;
  } serial_pins_s;

  localparam serial_pins_s PINS_IDLE = '{cs_n: 1'b1, cs_oe_n: 1'b1, sck: 1'b0,
                                         sck_oe_n: 1'b1, mosi: 1'b0, mosi_oe_n: 1'b1};

  typedef enum logic [2:0] {
    ST_TEST = 3'b000,
    ST_CMD  = 3'b001,
    ST_DATA = 3'b010,
    ST_RUN  = 3'b011,
    ST_HOST = 3'b100
  } boot_state_e;

  typedef enum logic [1:0] {
    EN_IDLE  = 2'b00,
    EN_SHIFT = 2'b01,
    EN_TAIL  = 2'b10
  } eng_state_e;

  // data words that follow a command byte, before any counts are read
  function automatic logic [10:0] words_for_cmd(input logic [7:0] cmd);
    unique case (cmd)
      CMD_WR_REG: words_for_cmd = 11'h002;
      CMD_FIR:    words_for_cmd = 11'h002;
      CMD_IIR:    words_for_cmd = 11'h008;
      CMD_ROM:    words_for_cmd = 11'h001;
      CMD_TBS:    words_for_cmd = 11'h001;
      default:    words_for_cmd = 11'h000;
    endcase
  endfunction : words_for_cmd
endpackage : boot_ctrl_pkg

/* File: verilog/eeprom_reader.sv */
// Purpose: one serial read transaction from the configuration eeprom
// Assumes: tick is a one-cycle pulse every half config clock period
// Notes: miso arrives already synchronised
`timescale 1ns/1ps
module eeprom_reader (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        tick,
  input  wire logic                        start,
  input  wire logic                        word,
  input  wire logic [15:0]                 addr,
  input  wire logic                        miso,
  output boot_ctrl_pkg::serial_pins_s      pins,
  output logic      [23:0]                 rdata,
  output logic                             done
);
  boot_ctrl_pkg::eng_state_e st_q;
  boot_ctrl_pkg::serial_pins_s pins_q;
  logic [31:0] tx_q;
  logic [5:0]  bit_q;
  logic [5:0]  last_q;
  logic [23:0] rdata_q;
  logic        done_q;

  assign pins  = pins_q;
  assign rdata = rdata_q;
  assign done  = done_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= boot_ctrl_pkg::EN_IDLE;
      pins_q  <= boot_ctrl_pkg::PINS_IDLE;
      tx_q    <= 32'h0;
      bit_q   <= 6'h0;
      last_q  <= 6'h0;
      rdata_q <= 24'h0;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (st_q)
        boot_ctrl_pkg::EN_IDLE: begin
          if (start) begin
            tx_q    <= {boot_ctrl_pkg::OP_READ, addr, 8'h00};
            bit_q   <= 6'h0;
            last_q  <= word ? boot_ctrl_pkg::LAST_WORD : boot_ctrl_pkg::LAST_BYTE;
            rdata_q <= 24'h0;
            pins_q  <= '{cs_n: 1'b0, cs_oe_n: 1'b0, sck: 1'b0, sck_oe_n: 1'b0,
                         mosi: boot_ctrl_pkg::OP_READ[7], mosi_oe_n: 1'b0};
            st_q    <= boot_ctrl_pkg::EN_SHIFT;
          end
        end
        boot_ctrl_pkg::EN_SHIFT: begin
          if (tick) begin
            if (!pins_q.sck) begin
              pins_q.sck <= 1'b1;
              if (bit_q >= boot_ctrl_pkg::HDR_BITS) begin
                rdata_q <= {rdata_q[22:0], miso};
              end
            end else begin
              pins_q.sck <= 1'b0;
              if (bit_q == last_q) begin
                pins_q.cs_n <= 1'b1;
                st_q        <= boot_ctrl_pkg::EN_TAIL;
              end else begin
                bit_q       <= bit_q + 6'h1;
                tx_q        <= {tx_q[30:0], 1'b0};
                pins_q.mosi <= tx_q[30];
              end
            end
          end
        end
        boot_ctrl_pkg::EN_TAIL: begin
          if (tick) begin
            pins_q <= boot_ctrl_pkg::PINS_IDLE;
            done_q <= 1'b1;
            st_q   <= boot_ctrl_pkg::EN_IDLE;
          end
        end
        default: st_q <= boot_ctrl_pkg::EN_IDLE;
      endcase
    end
  end
endmodule : eeprom_reader

/* File: testbench/eeprom_model.sv */
// Purpose: serial config eeprom answering read transactions
// Assumes: mode 0, opcode then 16-bit address
// Notes: logs each address; released data line toggles
`timescale 1ns/1ps
module eeprom_model (
  input  wire boot_ctrl_pkg::serial_pins_s pins,
  output logic                             miso,
  output logic [127:0]                     addr_seq,
  output logic                             op_bad
);
  logic [7:0]  mem [0:31];
  logic [23:0] hdr;
  logic [15:0] base;
  logic [15:0] ix;
  int          bits;
  wire         sel = !pins.cs_n && !pins.cs_oe_n;
  initial begin
    miso = 1'b0;
    addr_seq = '0;
    op_bad = 1'b0;
    bits = 0;
    hdr = '0;
    base = '0;
    foreach (mem[i]) mem[i] = 8'h00;
    mem[16] = 8'h01;
    mem[22] = 8'h01;
    mem[23] = 8'h04;
    mem[25] = 8'h22;
    mem[28] = 8'h06;
  end
  always @(negedge pins.cs_n) bits = 0;
  always @(posedge pins.sck) if (sel) begin
    hdr = {hdr[22:0], pins.mosi};
    bits++;
    if (bits == 24) begin
      base = hdr[15:0];
      op_bad |= (hdr[23:16] !== 8'h03);
      addr_seq = {addr_seq[111:0], hdr[15:0]};
    end
  end
  always @(negedge pins.sck) begin
    ix = base + 16'((bits - 24) / 8);
    if (sel && bits >= 24) miso = mem[ix[4:0]][7 - (bits - 24) % 8];
    else miso = ~miso;
  end
  always @(posedge pins.cs_n) miso = ~miso;
endmodule : eeprom_model

/* File: testbench/reset_boot_sync_controller_tb.sv */
// Purpose: bench for reset_boot_sync_controller
// Assumes: eeprom_model on the serial pins
// Notes: short self-test count
`timescale 1ns/1ps
module reset_boot_sync_controller_tb;
  logic clk = 0, rst_n = 0, boot_pin = 1, sync_pin = 0, psel = 0, penable = 0, pwrite = 0;
  logic [4:0]  check_fail = 5'h02;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, e, miso, align, restart, ptr, mclk, running, op_bad;
  logic [127:0] addr_seq;
  boot_ctrl_pkg::serial_pins_s pins;
  int          bad_count = 0, checked = 0, n_al = 0, n_ptr = 0, n_drv = 0, n_cyc = 0, s0;
  always #5 clk = ~clk;
  reset_boot_sync_controller #(.TEST_CYCLES(50)) reset_boot_sync_controller_inst (.clk(clk), .rst_n(rst_n),
    .boot_pin(boot_pin), .sync_pin(sync_pin), .miso_pin(miso), .check_fail(check_fail), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_pins(pins), .modulator_align_pulse(align), .filter_restart(restart),
    .stream_pointer_reset(ptr), .modulator_clock(mclk), .filter_running(running));
  eeprom_model eeprom_model_inst (.pins(pins), .miso(miso), .addr_seq(addr_seq), .op_bad(op_bad));
  always @(posedge clk) begin
    n_al += (align === 1'b1 && restart === 1'b1);
    n_ptr += (ptr === 1'b1);
    n_drv += (pins.cs_oe_n !== 1'b1 || pins.sck_oe_n !== 1'b1 || pins.mosi_oe_n !== 1'b1);
    n_cyc++;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic sync_edge;
    s0 = n_al;
    @(posedge clk);
    sync_pin <= 1'b1;
    repeat (4) @(posedge clk);
    sync_pin <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : sync_edge
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  initial begin
    #600000;
    bad_count++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b1, 8'h00, 32'h2); chk(64'(e), 64'h1);
    for (int i = 0; i < 40000 && running !== 1'b1; i++) @(posedge clk);
    chk(64'(running), 64'h1);
    chk(addr_seq[127:64], 64'h0000001000110014);
    chk(addr_seq[63:0], 64'h00170018001B001C);
    chk(64'(op_bad), 64'h0);
    chk(64'(pins), 64'(boot_ctrl_pkg::PINS_IDLE));
    @(posedge mclk);
    s0 = n_cyc;
    @(negedge mclk);
    chk(64'(n_cyc - s0), 64'(boot_ctrl_pkg::SCK_HALF));
    apb(1'b0, 8'hBC, 32'h0); chk(64'(r), 64'h0AAAFA);
    apb(1'b0, 8'h00, 32'h0); chk(64'(r), 64'h1);
    apb(1'b0, 8'hC0, 32'h0); chk(64'(r), 64'h3B);
    apb(1'b1, 8'hBC, 32'h5); chk(64'(e), 64'h1);
    apb(1'b0, 8'h04, 32'h0); chk(64'({e, r}), 64'h100000000);
    $display("boot test done");
    sync_edge(); chk(64'(n_al - s0), 64'h1);
    chk(64'(n_ptr), 64'h0);
    apb(1'b1, 8'hA8, 32'h3);
    sync_edge(); chk(64'(n_ptr), 64'h1);
    apb(1'b1, 8'h00, 32'h0);
    sync_edge(); chk(64'(n_al - s0), 64'h0);
    $display("sync test done");
    rst_n <= 1'b0;
    boot_pin <= 1'b0;
    check_fail <= 5'h00;
    repeat (12) @(posedge clk);
    chk(64'({pready, pins}), 64'(boot_ctrl_pkg::PINS_IDLE));
    rst_n <= 1'b1;
    s0 = n_drv;
    repeat (2000) @(posedge clk);
    chk(64'(n_drv - s0), 64'h0);
    apb(1'b0, 8'hC0, 32'h0); chk(64'(r), 64'h14);
    apb(1'b0, 8'hBC, 32'h0); chk(64'(r), 64'h0AAAAA);
    $display("host test done");
    finish_test();
  end
endmodule : reset_boot_sync_controller_tb
